// [hdl/wds_pkg.sv]
// Package for the winding diameter setup select block
package wds_pkg;

   // Setting widths
   localparam int DIA_W = 13;
   localparam int THK_W = 15;
   localparam int GEAR_W = 16;
   localparam int SPD_W = 16;
   localparam int PROD_W = 32;

   // Reset values and limits of the settings
   localparam logic [DIA_W-1:0] DIA_MAX_RST = 13'h0002;
   localparam logic [DIA_W-1:0] DIA_MIN_RST = 13'h0001;
   localparam logic [DIA_W-1:0] DIA_LIMIT_TOP = 13'h1999;
   localparam logic [DIA_W-1:0] DIA_LIMIT_BOT = 13'h0001;
   localparam logic [THK_W-1:0] THK_FIRST_RST = 15'h270F;
   localparam logic [THK_W-1:0] THK_OTHER_RST = 15'h03E8;
   localparam logic [THK_W-1:0] THK_OFF_CODE = 15'h270F;
   localparam logic [GEAR_W-1:0] GEAR_RST = 16'h0001;
   localparam logic [GEAR_W-1:0] GEAR_MIN = 16'h0001;
   localparam logic [GEAR_W-1:0] GEAR_MAX = 16'hFFFE;
   localparam logic [SPD_W-1:0] SPD_THR_RST = 16'h012C;
   localparam logic [SPD_W-1:0] SPD_THR_MAX = 16'h9C40;

   // Register offsets
   localparam logic [3:0] A_CTRL = 4'h0;
   localparam logic [3:0] A_GEAR_NUM = 4'h1;
   localparam logic [3:0] A_GEAR_DEN = 4'h2;
   localparam logic [3:0] A_SPD_THR = 4'h3;
   localparam logic [3:0] A_MAX0 = 4'h4;
   localparam logic [3:0] A_MIN0 = 4'h8;
   localparam logic [3:0] A_THK0 = 4'hC;
   localparam logic [1:0] A_DIA_SEL = 2'h1;
   localparam logic [1:0] A_MIN_SEL = 2'h2;
   localparam logic [1:0] A_THK_SEL = 2'h3;
   localparam logic [3:0] A_STATUS = 4'h0;

   // Control register fields
   localparam int C_ROLE = 0;
   localparam int C_DIR_ASG = 1;
   localparam int C_LOW_ASG = 2;
   localparam int C_HIGH_ASG = 3;
   localparam int C_INIT_CALC = 4;
   localparam int C_W = 5;

   // Shaft roles
   typedef enum logic [0:0] {
      WDS_WIND = 1'b0,
      WDS_UNWIND = 1'b1
   } wds_role_e;

   // One set of limits and thickness
   typedef struct packed {
      logic [DIA_W-1:0] dia_max;
      logic [DIA_W-1:0] dia_min;
      logic [THK_W-1:0] thk;
   } wds_set_s;

   // Selected operating view
   typedef struct packed {
      wds_role_e role;
      logic [1:0] set_idx;
      logic calc_enable;
      logic thk_method;
      logic update_ok;
   } wds_sel_s;

endpackage : wds_pkg

// [hdl/wds_sync2.sv]
// Two flip-flop synchroniser for one pin input
`timescale 1ns/1ps
module wds_sync2 (
   input wire logic i_core_clk, // Core clock
   input wire logic i_rst,      // Synchronous reset
   input wire logic i_async,    // Pin level
   output logic o_sync          // Synchronised level
);
   logic meta_r;

   // First stage feeds only the second
   always_ff @(posedge i_core_clk) begin
      if (i_rst) begin
         meta_r <= 1'b0;
         o_sync <= 1'b0;
      end else begin
         meta_r <= i_async;
         o_sync <= meta_r;
      end
   end
endmodule : wds_sync2

// [hdl/wds_setup_select.sv]
// Winding diameter setup select: role, gear, set selection, clamp and update gating
//
// Decided for this implementation: the register offsets and the address-and-strobe port.
`timescale 1ns/1ps
module wds_setup_select (
   input wire logic i_core_clk,                        // 200 MHz core clock
   input wire logic i_rst,                             // Synchronous reset, high
   input wire logic [3:0] i_addr,                      // Register address
   input wire logic [15:0] i_wdata,                    // Register write data
   input wire logic i_wr,                              // Write strobe
   input wire logic i_rd,                              // Read strobe
   output logic [15:0] o_rdata,                        // Read data, cycle after read
   input wire logic i_shaft_direction_input,           // Direction pin, high is ON
   input wire logic i_set_select_low,                  // Set select low pin
   input wire logic i_set_select_high,                 // Set select high pin
   input wire logic [wds_pkg::SPD_W-1:0] i_main_speed, // Main speed, 0.01Hz units
   input wire logic [wds_pkg::DIA_W-1:0] i_calc_dia,   // Raw computed diameter, mm
   input wire logic i_calc_valid,                      // Raw diameter valid pulse
   output logic [wds_pkg::DIA_W-1:0] o_dia,            // Held clamped diameter
   output logic [wds_pkg::DIA_W-1:0] o_start_dia,      // Starting diameter
   output logic [wds_pkg::THK_W-1:0] o_thk,            // Selected thickness
   output logic [wds_pkg::GEAR_W-1:0] o_gear_num,      // Gear numerator
   output logic [wds_pkg::GEAR_W-1:0] o_gear_den,      // Gear denominator
   output logic o_unwind,                              // High when unwinding
   output logic o_thk_method,                          // Thickness method chosen
   output logic o_calc_enable,                         // Calculator allowed to run
   output logic o_update_ok                            // Update gate open
);

   // ======================================================================
   // Pin synchronisers
   logic dir_s;
   logic low_s;
   logic high_s;

   wds_sync2 u_sync_dir (
      .i_core_clk(i_core_clk),
      .i_rst(i_rst),
      .i_async(i_shaft_direction_input),
      .o_sync(dir_s)
   );
   wds_sync2 u_sync_low (
      .i_core_clk(i_core_clk),
      .i_rst(i_rst),
      .i_async(i_set_select_low),
      .o_sync(low_s)
   );
   wds_sync2 u_sync_high (
      .i_core_clk(i_core_clk),
      .i_rst(i_rst),
      .i_async(i_set_select_high),
      .o_sync(high_s)
   );

   // ======================================================================
   // Settings registers
   logic [wds_pkg::C_W-1:0] ctrl_r;
   logic [wds_pkg::GEAR_W-1:0] gear_num_r;
   logic [wds_pkg::GEAR_W-1:0] gear_den_r;
   logic [wds_pkg::SPD_W-1:0] spd_thr_r;
   wds_pkg::wds_set_s sets_r [4];

   // Write decode
   wire wr_ctrl = i_wr && (i_addr == wds_pkg::A_CTRL);
   wire wr_num = i_wr && (i_addr == wds_pkg::A_GEAR_NUM);
   wire wr_den = i_wr && (i_addr == wds_pkg::A_GEAR_DEN);
   wire wr_thr = i_wr && (i_addr == wds_pkg::A_SPD_THR);
   wire [1:0] wr_grp = i_addr[3:2];
   wire [1:0] wr_idx = i_addr[1:0];
   wire [15:0] wd = i_wdata;

   // Out of range gear values are refused so the ratio never divides by zero
   wire num_ok = (wd >= wds_pkg::GEAR_MIN) && (wd <= wds_pkg::GEAR_MAX);
   wire thr_ok = (wd <= wds_pkg::SPD_THR_MAX);
   wire dia_ok = (wd[15:wds_pkg::DIA_W] == 3'h0)
                 && (wd[wds_pkg::DIA_W-1:0] >= wds_pkg::DIA_LIMIT_BOT)
                 && (wd[wds_pkg::DIA_W-1:0] <= wds_pkg::DIA_LIMIT_TOP);
   wire thk_ok = (wd[15] == 1'b0);

   // Scalar settings
   always_ff @(posedge i_core_clk) begin
      if (i_rst) begin
         ctrl_r <= '0;
         gear_num_r <= wds_pkg::GEAR_RST;
         gear_den_r <= wds_pkg::GEAR_RST;
         spd_thr_r <= wds_pkg::SPD_THR_RST;
      end else begin
         if (wr_ctrl) ctrl_r <= wd[wds_pkg::C_W-1:0];
         if (wr_num && num_ok) gear_num_r <= wd;
         if (wr_den && num_ok) gear_den_r <= wd;
         if (wr_thr && thr_ok) spd_thr_r <= wd;
      end
   end

   // Four sets of limits and thickness
   always_ff @(posedge i_core_clk) begin
      if (i_rst) begin
         for (int k = 0; k < 4; k++) begin
            sets_r[k].dia_max <= wds_pkg::DIA_MAX_RST;
            sets_r[k].dia_min <= wds_pkg::DIA_MIN_RST;
            sets_r[k].thk <= (k == 0) ? wds_pkg::THK_FIRST_RST : wds_pkg::THK_OTHER_RST;
         end
      end else if (i_wr) begin
         if (wr_grp == wds_pkg::A_DIA_SEL && dia_ok)
            sets_r[wr_idx].dia_max <= wd[wds_pkg::DIA_W-1:0];
         else if (wr_grp == wds_pkg::A_MIN_SEL && dia_ok)
            sets_r[wr_idx].dia_min <= wd[wds_pkg::DIA_W-1:0];
         else if (wr_grp == wds_pkg::A_THK_SEL && thk_ok)
            sets_r[wr_idx].thk <= wd[wds_pkg::THK_W-1:0];
      end
   end

   // ======================================================================
   // Selection logic
   wire dir_asg = ctrl_r[wds_pkg::C_DIR_ASG];
   wire low_asg = ctrl_r[wds_pkg::C_LOW_ASG];
   wire high_asg = ctrl_r[wds_pkg::C_HIGH_ASG];
   wire init_calc = ctrl_r[wds_pkg::C_INIT_CALC];

   // An unassigned select input reads as OFF
   wire sel_low = low_asg & low_s;
   wire sel_high = high_asg & high_s;
   wire [1:0] set_idx_nxt = {sel_high, sel_low};

   // Assigned direction input wins over the setting; ON means winding
   wire role_bit = dir_asg ? ~dir_s : ctrl_r[wds_pkg::C_ROLE];

   wds_pkg::wds_sel_s sel_r;
   wds_pkg::wds_set_s cur;
   assign cur = sets_r[sel_r.set_idx];

   // First set validity gates the whole calculator, whatever set is active
   wire calc_en_nxt = (sets_r[0].dia_min < sets_r[0].dia_max);
   wire thk_nxt = (sets_r[0].thk != wds_pkg::THK_OFF_CODE);
   wire upd_nxt = init_calc || (i_main_speed >= spd_thr_r);

   // Selection registered one cycle after the sampled input
   always_ff @(posedge i_core_clk) begin
      if (i_rst) begin
         sel_r <= '{role: wds_pkg::WDS_WIND, set_idx: 2'h0, calc_enable: 1'b0,
                    thk_method: 1'b0, update_ok: 1'b0};
      end else begin
         sel_r.role <= wds_pkg::wds_role_e'(role_bit);
         sel_r.set_idx <= set_idx_nxt;
         sel_r.calc_enable <= calc_en_nxt;
         sel_r.thk_method <= thk_nxt;
         sel_r.update_ok <= upd_nxt;
      end
   end

   // ======================================================================
   // Clamp and update
   wire [wds_pkg::DIA_W-1:0] clamp_lo = (i_calc_dia < cur.dia_min) ? cur.dia_min : i_calc_dia;
   wire [wds_pkg::DIA_W-1:0] clamped =
      (clamp_lo > cur.dia_max) ? cur.dia_max : clamp_lo;
   wire [wds_pkg::DIA_W-1:0] start_nxt =
      (sel_r.role == wds_pkg::WDS_WIND) ? cur.dia_min : cur.dia_max;
   wire take = i_calc_valid && sel_r.calc_enable && sel_r.update_ok;

   logic [wds_pkg::DIA_W-1:0] dia_r;
   logic [wds_pkg::DIA_W-1:0] start_r;
   logic [wds_pkg::THK_W-1:0] thk_r;
   logic started_r;

   // Diameter begins at the start value, then holds between accepted samples
   always_ff @(posedge i_core_clk) begin
      if (i_rst) begin
         dia_r <= wds_pkg::DIA_MIN_RST;
         start_r <= wds_pkg::DIA_MIN_RST;
         thk_r <= wds_pkg::THK_FIRST_RST;
         started_r <= 1'b0;
      end else begin
         start_r <= start_nxt;
         thk_r <= cur.thk;
         started_r <= 1'b1;
         if (!started_r) dia_r <= start_nxt;
         else if (take) dia_r <= clamped;
      end
   end

   // ======================================================================
   // Read back
   logic [15:0] rd_mux;
   wire [1:0] rd_grp = i_addr[3:2];
   wire [1:0] rd_idx = i_addr[1:0];
   wds_pkg::wds_set_s rd_set;
   assign rd_set = sets_r[rd_idx];
   wire [15:0] status_w = {7'h00, sel_r.update_ok, sel_r.calc_enable, sel_r.thk_method,
                           sel_r.set_idx, sel_r.role, high_s, low_s, dir_s};

   // Control word readback carries live status in its upper eleven bits
   always_comb begin
      rd_mux = 16'h0000;
      if (i_addr == wds_pkg::A_CTRL) rd_mux = {status_w[10:0], ctrl_r};
      else if (i_addr == wds_pkg::A_GEAR_NUM) rd_mux = gear_num_r;
      else if (i_addr == wds_pkg::A_GEAR_DEN) rd_mux = gear_den_r;
      else if (i_addr == wds_pkg::A_SPD_THR) rd_mux = spd_thr_r;
      else if (rd_grp == wds_pkg::A_DIA_SEL) rd_mux = {3'h0, rd_set.dia_max};
      else if (rd_grp == wds_pkg::A_MIN_SEL) rd_mux = {3'h0, rd_set.dia_min};
      else if (rd_grp == wds_pkg::A_THK_SEL) rd_mux = {1'b0, rd_set.thk};
   end

   always_ff @(posedge i_core_clk) begin
      if (i_rst) o_rdata <= 16'h0000;
      else if (i_rd) o_rdata <= rd_mux;
      else o_rdata <= 16'h0000;
   end

   // Outputs
   assign o_dia = dia_r;
   assign o_start_dia = start_r;
   assign o_thk = thk_r;
   assign o_gear_num = gear_num_r;
   assign o_gear_den = gear_den_r;
   assign o_unwind = sel_r.role;
   assign o_thk_method = sel_r.thk_method;
   assign o_calc_enable = sel_r.calc_enable;
   assign o_update_ok = sel_r.update_ok;

endmodule : wds_setup_select

// [sim/wds_setup_select_properties.sv]
// Port-level property checker for the winding diameter setup select block
`timescale 1ns/1ps
module wds_setup_select_props (
   input logic i_core_clk, // Clock
   input logic i_rst, // Reset
   input logic i_rd, // Read strobe
   input logic [15:0] o_rdata, // Read data
   input logic [wds_pkg::DIA_W-1:0] i_calc_dia, // Raw diameter
   input logic i_calc_valid, // Raw valid
   input logic [wds_pkg::DIA_W-1:0] o_dia, // Held diameter
   input logic [wds_pkg::DIA_W-1:0] o_start_dia, // Start diameter
   input logic [wds_pkg::GEAR_W-1:0] o_gear_num, // Numerator
   input logic [wds_pkg::GEAR_W-1:0] o_gear_den, // Denominator
   input logic o_unwind, // Role
   input logic o_calc_enable, // Calculator on
   input logic o_update_ok // Gate open
);
   default clocking @(posedge i_core_clk); endclocking
   default disable iff (i_rst);
   // An accepted raw diameter
   sequence s_upd;
      i_calc_valid && o_calc_enable && o_update_ok;
   endsequence
   // Same acceptance as a plain net, since a sequence method cannot feed $past
   wire acc_w = i_calc_valid && o_calc_enable && o_update_ok;
   a_rd_one_cycle: assert property (!$past(i_rd) |-> o_rdata == 16'h0000)
      else $error("read data outside its cycle");
   // Start diameter loads on the first edge out of reset, so the edges near it are skipped
   a_dia_held: assert property (!$past(i_rst, 3) && !$past(acc_w) |-> $stable(o_dia))
      else $error("diameter moved without update");
   a_clamp_min: assert property (s_upd ##0 (!o_unwind && i_calc_dia < o_start_dia)
      |=> o_dia == $past(o_start_dia)) else $error("winding clamp at minimum missed");
   a_clamp_max: assert property (s_upd ##0 (o_unwind && i_calc_dia > o_start_dia)
      |=> o_dia == $past(o_start_dia)) else $error("unwinding clamp at maximum missed");
   a_gear_num_range: assert property (o_gear_num != 16'h0000 && o_gear_num != 16'hFFFF)
      else $error("numerator out of range");
   a_gear_den_range: assert property (o_gear_den != 16'h0000 && o_gear_den != 16'hFFFF)
      else $error("denominator out of range");
   a_dia_range: assert property (o_dia >= 13'h0001 && o_dia <= 13'h1999)
      else $error("diameter out of range");
   a_start_range: assert property (o_start_dia >= 13'h0001 && o_start_dia <= 13'h1999)
      else $error("start diameter out of range");
endmodule : wds_setup_select_props
bind wds_setup_select wds_setup_select_props i_props (.i_core_clk(i_core_clk), .i_rst(i_rst),
   .i_rd(i_rd), .o_rdata(o_rdata), .i_calc_dia(i_calc_dia), .i_calc_valid(i_calc_valid),
   .o_dia(o_dia), .o_start_dia(o_start_dia), .o_gear_num(o_gear_num), .o_gear_den(o_gear_den),
   .o_unwind(o_unwind), .o_calc_enable(o_calc_enable), .o_update_ok(o_update_ok));

// [sim/wds_far_side.sv]
// Far side model: input terminals, motor speed and raw diameter source
`timescale 1ns/1ps
module wds_far_side (
   input logic i_core_clk, // Clock
   output logic o_dir = 1'b0, // Direction terminal
   output logic o_low = 1'b0, // Select low terminal
   output logic o_high = 1'b0, // Select high terminal
   output logic [15:0] o_speed = 16'h0000, // Motor speed
   output logic [12:0] o_calc_dia = 13'h0000, // Raw diameter
   output logic o_calc_valid = 1'b0 // Raw valid
);
   // Terminals only count once assigned by the control word
   task automatic pins(input logic d, input logic l, input logic h);
      @(posedge i_core_clk);
      o_dir <= d;
      o_low <= l;
      o_high <= h;
   endtask : pins
   task automatic speed(input logic [15:0] s);
      @(posedge i_core_clk);
      o_speed <= s;
   endtask : speed
   // Data is scrambled once valid drops so a stale sample cannot pass
   task automatic pulse(input logic [12:0] d);
      @(posedge i_core_clk);
      o_calc_dia <= d;
      o_calc_valid <= 1'b1;
      @(posedge i_core_clk);
      o_calc_valid <= 1'b0;
      o_calc_dia <= ~d;
   endtask : pulse
endmodule : wds_far_side

// [sim/tb_wds_setup_select.sv]
// Self-checking testbench for the winding diameter setup select block
`timescale 1ns/1ps
module tb_wds_setup_select;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic [3:0] addr = 4'h0;
   logic [15:0] wdata = 16'h0000;
   logic wr = 1'b0;
   logic rd = 1'b0;
   logic dir, lo, hi, cval, unw, tmeth, cen, upok;
   logic [15:0] rdata, spd, gnum, gden;
   logic [12:0] cdia, dia, sdia;
   logic [14:0] thk;
   int num_errors = 0;
   int n_compared = 0;
   int cyc = 0;
   always #2.5 clk = ~clk;
   wds_setup_select i_dut (.i_core_clk(clk), .i_rst(rst), .i_addr(addr), .i_wdata(wdata),
      .i_wr(wr), .i_rd(rd), .o_rdata(rdata), .i_shaft_direction_input(dir),
      .i_set_select_low(lo), .i_set_select_high(hi), .i_main_speed(spd), .i_calc_dia(cdia),
      .i_calc_valid(cval), .o_dia(dia), .o_start_dia(sdia), .o_thk(thk), .o_gear_num(gnum),
      .o_gear_den(gden), .o_unwind(unw), .o_thk_method(tmeth), .o_calc_enable(cen),
      .o_update_ok(upok));
   wds_far_side i_far (.i_core_clk(clk), .o_dir(dir), .o_low(lo), .o_high(hi), .o_speed(spd),
      .o_calc_dia(cdia), .o_calc_valid(cval));
   task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
      n_compared++;
      if (seen !== exp) begin
         num_errors++;
         $display("BAD %s expected %h seen %h", nm, exp, seen);
      end
   endtask : chk
   task automatic wrr(input logic [3:0] a, input logic [15:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask : wrr
   task automatic rdc(input logic [3:0] a, input logic [15:0] e);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1 chk("rdata", rdata, e);
   endtask : rdc
   task automatic t_reset;
      for (int a = 1; a < 16; a++) begin
         rdc(4'(a), (a < 3 || (a > 7 && a < 12)) ? 16'h0001 : (a == 3) ? 16'h012C :
            (a < 8) ? 16'h0002 : (a == 12) ? 16'h270F : 16'h03E8);
      end
      chk("dia", 16'(dia), 16'h0001);
      chk("method", 16'(tmeth), 16'h0000);
   endtask : t_reset
   // Out-of-range gear values must leave the old setting standing
   task automatic t_gear;
      wrr(4'h1, 16'h0000);
      wrr(4'h2, 16'hFFFF);
      rdc(4'h1, 16'h0001);
      chk("den", gden, 16'h0001);
      wrr(4'h1, 16'hFFFE);
      #1 chk("num", gnum, 16'hFFFE);
      wrr(4'h2, 16'h0032);
      wrr(4'h1, 16'h0001);
      chk("den", gden, 16'h0032);
   endtask : t_gear
   task automatic t_role;
      wrr(4'h0, 16'h0001);
      repeat (3) @(posedge clk);
      #1 chk("unwind", 16'(unw), 16'h0001);
      chk("start", 16'(sdia), 16'h0002);
      for (int p = 0; p < 2; p++) begin
         i_far.pins(p[0], 1'b0, 1'b0);
         wrr(4'h0, 16'h0003);
         repeat (4) @(posedge clk);
         #1 chk("unwind", 16'(unw), 16'(!p[0]));
      end
   endtask : t_role
   task automatic t_sets;
      for (int k = 0; k < 4; k++) begin
         wrr(4'(4 + k), 16'h0100 + 16'(k));
         wrr(4'(8 + k), 16'h0010 + 16'(k));
         wrr(4'(12 + k), 16'h0200 + 16'(k));
      end
      wrr(4'h0, 16'h000C);
      for (int k = 0; k < 4; k++) begin
         i_far.pins(1'b0, k[0], k[1]);
         repeat (4) @(posedge clk);
         #1 chk("thk", 16'(thk), 16'h0200 + 16'(k));
         chk("start", 16'(sdia), 16'h0010 + 16'(k));
      end
      wrr(4'h0, 16'h0000);
      repeat (3) @(posedge clk);
      #1 chk("start", 16'(sdia), 16'h0010);
      chk("method", 16'(tmeth), 16'h0001);
      // Both select pins ON but unassigned: status must still show set 0
      rdc(4'h0, 16'h18C0);
   endtask : t_sets
   task automatic upd(input logic [15:0] c, s, input logic [12:0] d, e);
      wrr(4'h0, c);
      i_far.speed(s);
      repeat (3) @(posedge clk);
      i_far.pulse(d);
      repeat (2) @(posedge clk);
      #1 chk("dia", 16'(dia), 16'(e));
   endtask : upd
   // Set 0 now holds minimum 0x10 and maximum 0x100
   task automatic t_upd;
      upd(16'h0000, 16'h012B, 13'h0050, 13'h0001);
      chk("upd_ok", 16'(upok), 16'h0000);
      upd(16'h0000, 16'h012C, 13'h0050, 13'h0050);
      chk("upd_ok", 16'(upok), 16'h0001);
      upd(16'h0000, 16'h012C, 13'h0500, 13'h0100);
      upd(16'h0000, 16'h012C, 13'h0001, 13'h0010);
      upd(16'h0010, 16'h0000, 13'h0060, 13'h0060);
      chk("upd_ok", 16'(upok), 16'h0001);
      upd(16'h0001, 16'h012C, 13'h0500, 13'h0100);
      upd(16'h0001, 16'h012C, 13'h0090, 13'h0090);
      wrr(4'h8, 16'h0180);
      upd(16'h0001, 16'h012C, 13'h0070, 13'h0090);
      chk("calc_en", 16'(cen), 16'h0000);
   endtask : t_upd
   task automatic close_out;
      $display("Compared %0d mismatches %0d", n_compared, num_errors);
      if (num_errors == 0 && n_compared > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask : close_out
   // Hang guard, far above the few hundred cycles the run needs
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         num_errors++;
         close_out();
      end
   end
   initial begin
      repeat (6) @(posedge clk);
      rst <= 1'b0;
      t_reset();
      t_gear();
      t_role();
      t_sets();
      t_upd();
      close_out();
   end
endmodule : tb_wds_setup_select
